// ---- rc_charge_time_capacitance_meter_tb.sv ----
// Self-checking bench for the capacitance meter
module rc_charge_time_capacitance_meter_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, sys_rst, timebase_clk_in, keypad_press, comparator_in;
   logic        charge_drive_output, timebase_run, measure_done, high_range;
   logic [7:0]  range_switch_input, dac_ref_code, unit_segments, micro_segments;
   logic [15:0] pulse_count, trip, lfsr;
   logic [19:0] display_bcd;
   logic [3:0]  display_dp;
   int          n_errors, tests_run;
   rcm_meter DUT (.clk, .sys_rst, .timebase_clk_in, .keypad_press, .comparator_in,
      .range_switch_input, .charge_drive_output, .dac_ref_code, .timebase_run, .pulse_count,
      .measure_done, .high_range, .display_bcd, .display_dp, .unit_segments, .micro_segments);
   // Fast oscillator keeps the run short; the meter only counts its edges
   rcm_rc_model #(.TB_PERIOD_NS(80)) u_rc (.charge_drive_output, .trip_edges(trip),
      .timebase_clk_in, .comparator_in);
   function automatic logic [19:0] to_bcd(input logic [15:0] v);
      logic [19:0] r;
      for (int i = 0; i < 5; i++) begin
         r[4*i +: 4] = 4'(v % 16'h000A);
         v = v / 16'h000A;
      end
      return r;
   endfunction : to_bcd
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr_next
   task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic tally_and_finish;
      if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   // Bounded wait, sampled on the falling edge where outputs are settled
   task automatic wait_lvl(ref logic s, input logic lvl, input string what);
      for (int i = 0; i < 40000 && s !== lvl; i++) @(negedge clk);
      check(what, 20'(lvl), 20'(s));
   endtask : wait_lvl
   // Key held four cycles: long enough to pass the input filter
   task automatic press_key(input logic [7:0] s);
      @(posedge clk);
      range_switch_input <= s;
      keypad_press <= 1'b1;
      repeat (4) @(posedge clk);
      keypad_press <= 1'b0;
   endtask : press_key
   task automatic measure(input logic rng, input logic [15:0] n);
      logic [15:0] rel;
      rel = rng ? 16'h03E8 : 16'h000A;
      lfsr = lfsr_next(lfsr);
      @(posedge clk);
      range_switch_input <= {lfsr[7:1], rng};
      trip <= 16'(n * rel + rel / 16'h0002);
      repeat (8) @(posedge clk);
      press_key({lfsr[7:1], rng});
      wait_lvl(charge_drive_output, 1'b1, "charge");
      check("count_start", 20'h00000, 20'(pulse_count));
      press_key({lfsr[15:9], ~rng});
      @(negedge clk);
      check("key_ignored", 20'h00001, 20'(charge_drive_output));
      wait_lvl(measure_done, 1'b1, "done");
      check("run_off", 20'h00000, 20'(timebase_run));
      repeat (2) @(negedge clk);
      check("count", 20'(n), 20'(pulse_count));
      check("bcd", to_bcd(n), display_bcd);
      check("range", 20'(rng), 20'(high_range));
      check("dp", 20'(rng ? 4'h2 : 4'h8), 20'(display_dp));
      check("legend", 20'h017C1, 20'({unit_segments, micro_segments}));
      repeat (20) @(negedge clk);
      check("held", 20'(n), 20'(pulse_count));
      press_key(range_switch_input);
      wait_lvl(measure_done, 1'b0, "restart");
      repeat (2) @(negedge clk);
      check("cleared", 20'h00000, display_bcd);
      check("discharge", 20'h00000, 20'(charge_drive_output));
      check("ref_code", 20'h00001, 20'(dac_ref_code));
   endtask : measure
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Trip points span no pulse, a random few, and both ranges
   initial begin
      {n_errors, tests_run} = '0;
      lfsr = 16'h01C2;
      {sys_rst, keypad_press, range_switch_input, trip} = {1'b1, 1'b0, 8'h00, 16'hFFFF};
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      measure(1'b0, 16'h0000);
      measure(1'b0, 16'(lfsr[4:0]) + 16'h0001);
      measure(1'b1, 16'h0001);
      measure(1'b1, 16'h0002);
      tally_and_finish();
   end
   // About two and a half times the expected run of some 41000 cycles
   initial begin
      #800000;
      n_errors++;
      tally_and_finish();
   end
endmodule : rc_charge_time_capacitance_meter_tb

// ---- rcm_meter.sv ----
// RC charge-time capacitance meter: sequencing, pulse count and display data
module rcm_meter
   import rcm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        timebase_clk_in,
   input  wire logic        keypad_press,
   input  wire logic        comparator_in,
   input  wire logic [7:0]  range_switch_input,
   output logic             charge_drive_output,
   output logic [7:0]       dac_ref_code,
   output logic             timebase_run,
   output logic [15:0]      pulse_count,
   output logic             measure_done,
   output logic             high_range,
   output logic [19:0]      display_bcd,
   output logic [3:0]       display_dp,
   output logic [7:0]       unit_segments,
   output logic [7:0]       micro_segments
);

   rcm_state_t        state;
   rcm_state_t        next_state;

   logic [SYNC_W-1:0] sync_a;
   logic [SYNC_W-1:0] sync_b;
   logic [SYNC_W-1:0] sync_c;
   logic [SYNC_W-1:0] filt;
   logic [SYNC_W-1:0] filt_prev;
   logic [SYNC_W-1:0] pin_bundle;

   logic              tb_step;
   logic              key_rise;
   logic              cmp_high;
   logic              tb_tick;
   logic [15:0]       reload_value;
   logic              charging_next;
   logic              stop_now;
   logic              count_enable;
   logic [15:0]       next_pulse_count;
   logic [19:0]       next_display_bcd;

   // Gather the asynchronous pins into one bundle for the synchroniser.
   // Only switch bit 0 matters; the other switches are never sampled.
   assign pin_bundle = {range_switch_input[RANGE_BIT], comparator_in,
                        keypad_press, timebase_clk_in};

   // First stage takes the raw pins; it may go metastable, so only stage two reads it
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync_a <= '0;
      end else begin
         sync_a <= pin_bundle;
      end
   end

   // Second stage settles the first
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync_b <= '0;
      end else begin
         sync_b <= sync_a;
      end
   end

   // Third stage, compared against the second by the filter
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync_c <= '0;
      end else begin
         sync_c <= sync_b;
      end
   end

   // A pin level is accepted once stages two and three agree on it;
   // a change that lasts a single cycle is thus ignored.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         filt <= '0;
      end else begin
         for (int i = 0; i < SYNC_W; i++) begin
            if (sync_b[i] == sync_c[i]) begin
               filt[i] <= sync_c[i];
            end
         end
      end
   end

   // Previous accepted levels, for edge detection
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         filt_prev <= '0;
      end else begin
         filt_prev <= filt;
      end
   end

   // One time-base step per rising edge of the input clock (one full cycle)
   assign tb_step  = filt[SI_TBCLK] && !filt_prev[SI_TBCLK];
   // Keypad acts on its press edge, so a held key starts only one run
   assign key_rise = filt[SI_KEY] && !filt_prev[SI_KEY];
   assign cmp_high = filt[SI_CMP];
   // Comparator only ends a run; outside charging it is ignored
   assign stop_now = (state == RCM_CHARGE) && cmp_high;

   // Range choice follows the switch only while waiting for start
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         high_range <= 1'b0;
      end else if (state == RCM_WAIT_KEY) begin
         high_range <= filt[SI_RANGE];
      end
   end

   // Reload count picked by range
   assign reload_value = high_range ? RELOAD_HIGH_RANGE : RELOAD_LOW_RANGE;

   // Measurement sequence
   always_comb begin
      next_state = state;
      unique case (state)
         RCM_WAIT_KEY: begin
            if (key_rise) begin
               next_state = RCM_CHARGE;
            end
         end
         RCM_CHARGE: begin
            if (stop_now) begin
               next_state = RCM_SHOW;
            end
         end
         RCM_SHOW: begin
            if (key_rise) begin
               next_state = RCM_WAIT_KEY;
            end
         end
      endcase
   end

   // State register; reset lands in the discharge-and-wait step
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= RCM_WAIT_KEY;
      end else begin
         state <= next_state;
      end
   end

   // Charging whenever the sequence is entering or staying in the charge step
   assign charging_next = (next_state == RCM_CHARGE);

   // Time-base runs only while charging; the count is frozen by its charge-state enable, not by this stop
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         timebase_run <= 1'b0;
      end else begin
         timebase_run <= charging_next;
      end
   end

   // Charge drive shares the run condition, so both rise on the same edge
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         charge_drive_output <= 1'b0;
      end else begin
         charge_drive_output <= charging_next;
      end
   end

   // Reference code is held at its low threshold for every measurement;
   // a fixed code keeps the trip point, and so calibration, equal in both ranges
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dac_ref_code <= REF_CODE;
      end else begin
         dac_ref_code <= REF_CODE;
      end
   end

   // Reloading down-counter; it takes its reload value only while stopped,
   // so a range change can never cut a period short
   rcm_timebase u_timebase (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .run          (timebase_run),
      .step         (tb_step),
      .reload_value (reload_value),
      .tick         (tb_tick)
   );

   // Count only time-base pulses during charge; a pulse in the stop cycle is dropped.
   // Saturates rather than wraps, so an oversize part reads full scale.
   assign count_enable = (state == RCM_CHARGE) && !cmp_high && tb_tick
                         && (pulse_count != COUNT_SATURATE);

   // Next count: cleared while waiting, held once frozen
   always_comb begin
      next_pulse_count = pulse_count;
      if (state == RCM_WAIT_KEY) begin
         next_pulse_count = COUNT_RESET;
      end else if (count_enable) begin
         next_pulse_count = pulse_count + 16'h0001;
      end
   end

   // Pulse count register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pulse_count <= COUNT_RESET;
      end else begin
         pulse_count <= next_pulse_count;
      end
   end

   // Result flag shows the count is frozen; the display takes it one cycle later
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         measure_done <= 1'b0;
      end else begin
         measure_done <= (next_state == RCM_SHOW);
      end
   end

   // Binary to packed BCD by shift-and-add-three, five digits for 16 bits
   function automatic logic [19:0] rcm_to_bcd(input logic [15:0] bin);
      logic [19:0] bcd;
      bcd = BCD_RESET;
      for (int b = 15; b >= 0; b--) begin
         for (int d = 0; d < 5; d++) begin
            if (bcd[d*4 +: 4] > 4'h4) begin
               bcd[d*4 +: 4] = bcd[d*4 +: 4] + 4'h3;
            end
         end
         bcd = {bcd[18:0], bin[b]};
      end
      return bcd;
   endfunction : rcm_to_bcd

   // Digits read zero while waiting and take the count once it is frozen.
   // Converting in one cycle costs logic but avoids a conversion handshake.
   always_comb begin
      next_display_bcd = display_bcd;
      if (state == RCM_WAIT_KEY) begin
         next_display_bcd = BCD_RESET;
      end else if (state == RCM_SHOW) begin
         next_display_bcd = rcm_to_bcd(pulse_count);
      end
   end

   // Display digit register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         display_bcd <= BCD_RESET;
      end else begin
         display_bcd <= next_display_bcd;
      end
   end

   // Decimal point tracks the sampled range; only one point ever lit.
   // It trails the range by one cycle, so it can settle one cycle after a start.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         display_dp <= DP_LOW_RANGE;
      end else begin
         display_dp <= high_range ? DP_HIGH_RANGE : DP_LOW_RANGE;
      end
   end

   // Unit letter on digit 0, fixed for good
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         unit_segments <= UNIT_SEG_PATTERN;
      end else begin
         unit_segments <= UNIT_SEG_PATTERN;
      end
   end

   // Micro symbol on digit 1, fixed for good
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         micro_segments <= MICRO_SEG_PATTERN;
      end else begin
         micro_segments <= MICRO_SEG_PATTERN;
      end
   end

endmodule : rcm_meter

// ---- rcm_meter_chk.sv ----
// Port assertions for the capacitance meter, bound into its top module
module rcm_meter_chk (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        charge_drive_output,
   input wire logic [7:0]  dac_ref_code,
   input wire logic        timebase_run,
   input wire logic [15:0] pulse_count,
   input wire logic        measure_done,
   input wire logic        high_range,
   input wire logic [3:0]  display_dp,
   input wire logic [7:0]  unit_segments,
   input wire logic [7:0]  micro_segments
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // Charge start and stop, each seen across two cycles
   sequence s_rise;
      !charge_drive_output ##1 charge_drive_output;
   endsequence
   sequence s_fall;
      charge_drive_output ##1 !charge_drive_output;
   endsequence
   property p_ref; dac_ref_code == 8'h01; endproperty
   a_ref: assert property (p_ref)
      else $error("reference code wrong");
   property p_legend; unit_segments == 8'h17 && micro_segments == 8'hC1; endproperty
   a_legend: assert property (p_legend)
      else $error("legend pattern wrong");
   property p_pair; timebase_run == charge_drive_output; endproperty
   a_pair: assert property (p_pair)
      else $error("run and charge apart");
   // The point register follows the latched range one cycle later
   property p_dp; display_dp == ($past(high_range) ? 4'h2 : 4'h8); endproperty
   a_dp: assert property (p_dp)
      else $error("decimal point wrong");
   // A run must begin from a cleared count
   property p_start; s_rise |-> pulse_count == 16'h0000 && !measure_done; endproperty
   a_start: assert property (p_start)
      else $error("start not clean");
   property p_stop; s_fall |-> measure_done; endproperty
   a_stop: assert property (p_stop)
      else $error("stop without result");
   property p_frozen; measure_done ##1 measure_done |-> $stable(pulse_count); endproperty
   a_frozen: assert property (p_frozen)
      else $error("result moved");
   property p_step;
      $changed(pulse_count) |-> pulse_count == $past(pulse_count) + 16'h0001
         || pulse_count == 16'h0000;
   endproperty
   a_step: assert property (p_step)
      else $error("count jumped");
   // Range must not follow the switch once charging
   property p_hold; charge_drive_output ##1 charge_drive_output |-> $stable(high_range); endproperty
   a_hold: assert property (p_hold)
      else $error("range changed");
endmodule : rcm_meter_chk

bind rcm_meter rcm_meter_chk u_chk (.clk, .sys_rst, .charge_drive_output, .dac_ref_code,
   .timebase_run, .pulse_count, .measure_done, .high_range, .display_dp, .unit_segments,
   .micro_segments);

// ---- rcm_pkg.sv ----
// Constants shared by the capacitance meter and its time-base down-counter
package rcm_pkg;

   // Time-base input clock, as delivered on its pin
   localparam int unsigned TB_CLK_HZ          = 307200;
   // System clock period in ns
   localparam int unsigned SYS_CLK_PERIOD_NS  = 8;
   // System cycles in one time-base half period, rounded down (about 203)
   localparam int unsigned TB_HALF_CYCLES     =
      1000000000 / (2 * TB_CLK_HZ * SYS_CLK_PERIOD_NS);

   // Reload counts for the two ranges
   localparam logic [15:0] RELOAD_LOW_RANGE   = 16'h000A;
   localparam logic [15:0] RELOAD_HIGH_RANGE  = 16'h03E8;

   // Comparator reference code applied during every measurement
   localparam logic [7:0]  REF_CODE           = 8'h01;

   // Fixed legend patterns for display digits 0 and 1
   localparam logic [7:0]  UNIT_SEG_PATTERN   = 8'h17;
   localparam logic [7:0]  MICRO_SEG_PATTERN  = 8'hC1;

   // Bit of the switch input that selects the range (1 = high range)
   localparam int unsigned RANGE_BIT          = 0;

   // Decimal point positions within the numeric digits (0 = ones)
   localparam logic [3:0]  DP_HIGH_RANGE      = 4'h2;
   localparam logic [3:0]  DP_LOW_RANGE       = 4'h8;

   // Reset values and the count saturation limit
   localparam logic [15:0] COUNT_RESET        = 16'h0000;
   localparam logic [15:0] COUNT_SATURATE     = 16'hFFFF;
   localparam logic [19:0] BCD_RESET          = 20'h00000;

   // Index of each synchronised pin within the input bundle
   localparam int unsigned SYNC_W             = 4;
   localparam int unsigned SI_TBCLK           = 0;
   localparam int unsigned SI_KEY             = 1;
   localparam int unsigned SI_CMP             = 2;
   localparam int unsigned SI_RANGE           = 3;

   // Measurement sequence states
   typedef enum logic [1:0] {
      RCM_WAIT_KEY,
      RCM_CHARGE,
      RCM_SHOW
   } rcm_state_t;

endpackage : rcm_pkg

// ---- rcm_rc_model.sv ----
// Far side: time-base oscillator, RC network and comparator
module rcm_rc_model #(
   parameter int TB_PERIOD_NS = 3256
) (
   input  wire logic        charge_drive_output,
   input  wire logic [15:0] trip_edges,
   output logic             timebase_clk_in,
   output logic             comparator_in
);
   timeunit 1ns;
   timeprecision 1ps;
   int edges;
   // Oscillator runs free, as a crystal-fed time-base would
   initial begin
      timebase_clk_in = 1'b0;
      forever #(TB_PERIOD_NS / 2) timebase_clk_in = ~timebase_clk_in;
   end
   // Trip on a low half so the trip never lands on a step edge
   initial begin
      comparator_in = 1'b0;
      edges = 0;
      forever begin
         @(timebase_clk_in or charge_drive_output);
         if (!charge_drive_output) begin
            edges = 0;
            comparator_in = 1'b0;
         end else if (timebase_clk_in) begin
            edges++;
         end else if (edges >= int'(trip_edges)) begin
            comparator_in = 1'b1;
         end
      end
   end
endmodule : rcm_rc_model

// ---- rcm_timebase.sv ----
// Reloading time-base down-counter producing one tick per terminal count
module rcm_timebase
   import rcm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        run,
   input  wire logic        step,
   input  wire logic [15:0] reload_value,
   output logic             tick
);

   logic [15:0] timebase_pulse_reload_setting;
   logic [15:0] count;

   // Stored count is taken while stopped, so a range change never hits mid-run
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         timebase_pulse_reload_setting <= RELOAD_LOW_RANGE;
      end else if (!run) begin
         timebase_pulse_reload_setting <= reload_value;
      end
   end

   // Down-count one per input clock cycle, reload in place of the step from one to zero
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count <= RELOAD_LOW_RANGE;
      end else if (!run) begin
         count <= reload_value;
      end else if (step) begin
         if (count == 16'h0001) begin
            count <= timebase_pulse_reload_setting;
         end else begin
            count <= count - 16'h0001;
         end
      end
   end

   // Single pulse per terminal count, then keep running
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick <= 1'b0;
      end else begin
         tick <= run && step && (count == 16'h0001);
      end
   end

endmodule : rcm_timebase
